// ### core/adc_mux_pkg.sv
// Package with register map, field layout, codes and timing for the converter control block.
// Function
// - Five-bit input select field at bits 6:2.
// - Codes 00000-01111 route internal signals, 01000/01001 reserved.
// - Codes 10000-10111 connect no source.
// - Codes 11000-11111 route pin channels 0-7; channels 5-7 (11101-11111) only with the large package.
// - Writing go flag with power bit set starts conversion; reads busy.
// - Hardware clears go flag on conversion completion.
// - Power bit one enables converter, zero off.
// - Bit 7 reads zero, writes ignored.
// - Selected signal drives buffer to port pin.
package adc_mux_pkg;

    // ********************************************
    // Register map
    // ********************************************
    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_BENCH     = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = 4'hc;

    localparam logic [7:0] CONTROL_RESET   = 8'h00;
    localparam logic [7:0] CONTROL_WR_MASK = 8'h7f;
    localparam int unsigned POWER_BIT      = 0;
    localparam int unsigned GO_BIT         = 1;
    localparam int unsigned SEL_LSB        = 2;
    localparam int unsigned SEL_MSB        = 6;
    localparam int unsigned BENCH_EN_BIT   = 0;

    // Interrupt status bits.
    localparam int unsigned IRQ_W          = 2;
    localparam int unsigned IRQ_DONE_BIT   = 0;
    localparam int unsigned IRQ_ABORT_BIT  = 1;

    // ********************************************
    // Selection codes
    // ********************************************
    localparam logic [4:0] SEL_RSVD_A      = 5'h08;
    localparam logic [4:0] SEL_RSVD_B      = 5'h09;
    localparam logic [1:0] SEL_GRP_INT_LO  = 2'h0;
    localparam logic [1:0] SEL_GRP_INT_HI  = 2'h1;
    localparam logic [1:0] SEL_GRP_NONE    = 2'h2;
    localparam logic [1:0] SEL_GRP_PIN     = 2'h3;
    localparam logic [4:0] SEL_PIN_LAST_SMALL = 5'h1c;

    // ********************************************
    // Timing
    // ********************************************
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned CONV_TIME_NS   = 2000;
    localparam int unsigned CONV_CYCLES    = (CONV_TIME_NS * CLK_MHZ) / 1000;
    localparam int unsigned CNT_W          = 16;

    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_IDLE = 2'b01,
        ST_CONV = 2'b11
    } conv_state_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } bus_req_type;

    typedef struct packed {
        logic       source_valid;
        logic       source_internal;
        logic       source_pin;
        logic [3:0] source_index;
    } route_type;

endpackage

// ### core/adc_route_decode.sv
// Decoder from the input select code to the analog route.
`timescale 1ns/1ps
module adc_route_decode (
    input  wire logic [4:0]             code_i,
    input  wire logic                   large_pkg_i,
    output adc_mux_pkg::route_type      route_o
);
    import adc_mux_pkg::*;

    always_comb begin
        route_o = '0;
        route_o.source_index = code_i[3:0];
        unique case (code_i[4:3])
            SEL_GRP_INT_LO: begin
                route_o.source_internal = 1'b1;
                route_o.source_valid    = 1'b1;
            end
            SEL_GRP_INT_HI: begin
                route_o.source_internal = (code_i != SEL_RSVD_A) && (code_i != SEL_RSVD_B);
                route_o.source_valid    = route_o.source_internal;
            end
            SEL_GRP_NONE: begin
                route_o.source_valid = 1'b0;
            end
            SEL_GRP_PIN: begin
                route_o.source_index = {1'b0, code_i[2:0]};
                route_o.source_pin   = (code_i <= SEL_PIN_LAST_SMALL) || large_pkg_i;
                route_o.source_valid = route_o.source_pin;
            end
        endcase
    end
endmodule

// ### core/adc_sync2.sv
// Two-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/1ps
module adc_sync2 (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// ### core/adc_mux_control.sv
// Converter control register, conversion sequencer, route outputs and interrupt.
`timescale 1ns/1ps
module adc_mux_control #(
    parameter int unsigned CONV_CYCLES_P = adc_mux_pkg::CONV_CYCLES
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic [adc_mux_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [7:0]                    wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [7:0]                    rdata_o,
    input  wire logic                          conv_done_i,
    input  wire logic                          large_pkg_i,
    output logic                               converter_power_o,
    output logic                               conv_start_o,
    output logic                               route_valid_o,
    output logic                               route_internal_o,
    output logic                               route_pin_o,
    output logic      [3:0]                    route_index_o,
    output logic                               bench_buffer_en_o,
    output logic                               irq_o
);
    import adc_mux_pkg::*;

    // ********************************************
    // Input capture
    // ********************************************
    // The converter finish flag comes from the analog side, so it is synchronised.
    logic done_sync;
    logic done_prev;
    logic done_rise;
    logic large_sync;

    adc_sync2 u_done_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (conv_done_i),
        .q_o     (done_sync)
    );

    adc_sync2 u_pkg_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (large_pkg_i),
        .q_o     (large_sync)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            done_prev <= 1'b0;
        end else begin
            done_prev <= done_sync;
        end
    end

    assign done_rise = done_sync && !done_prev;

    // ********************************************
    // Bus decode
    // ********************************************
    bus_req_type req;
    logic        wr_control;
    logic        wr_bench;
    logic        wr_stat;
    logic        wr_mask;

    assign req        = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign wr_control = req.wr && (req.addr == ADDR_CONTROL);
    assign wr_bench   = req.wr && (req.addr == ADDR_BENCH);
    assign wr_stat    = req.wr && (req.addr == ADDR_IRQ_STAT);
    assign wr_mask    = req.wr && (req.addr == ADDR_IRQ_MASK);

    // ********************************************
    // Control register
    // ********************************************
    logic [4:0]     input_select_field;
    logic           converter_power_bit;
    logic           bench_output_control;
    conv_state_type state;
    logic [CNT_W-1:0] conv_count;
    logic           conv_finish;
    logic           conv_abort;
    logic           go_req;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            input_select_field  <= CONTROL_RESET[SEL_MSB:SEL_LSB];
            converter_power_bit <= CONTROL_RESET[POWER_BIT];
        end else if (wr_control) begin
            input_select_field  <= req.wdata[SEL_MSB:SEL_LSB];
            converter_power_bit <= req.wdata[POWER_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bench_output_control <= 1'b0;
        end else if (wr_bench) begin
            bench_output_control <= req.wdata[BENCH_EN_BIT];
        end
    end

    // A go write needs the power bit in the same write, since power off aborts.
    assign go_req = wr_control && req.wdata[GO_BIT] && req.wdata[POWER_BIT];

    // ********************************************
    // Conversion sequencer
    // ********************************************
    // Completion is either the converter flag or the local timeout, whichever first.
    assign conv_finish = (state == ST_CONV) &&
                         (done_rise || (conv_count == CNT_W'(CONV_CYCLES_P - 1)));
    assign conv_abort  = (state == ST_CONV) && wr_control && !req.wdata[POWER_BIT];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state      <= ST_OFF;
            conv_count <= '0;
        end else begin
            unique case (state)
                ST_OFF: begin
                    if (go_req) begin
                        state <= ST_CONV;
                    end else if (wr_control && req.wdata[POWER_BIT]) begin
                        state <= ST_IDLE;
                    end
                    conv_count <= '0;
                end
                ST_IDLE: begin
                    if (go_req) begin
                        state <= ST_CONV;
                    end else if (wr_control && !req.wdata[POWER_BIT]) begin
                        state <= ST_OFF;
                    end
                    conv_count <= '0;
                end
                ST_CONV: begin
                    if (conv_abort) begin
                        state <= ST_OFF;
                    end else if (conv_finish) begin
                        state <= ST_IDLE;
                    end
                    conv_count <= conv_count + CNT_W'(1);
                end
                default: begin
                    state      <= ST_OFF;
                    conv_count <= '0;
                end
            endcase
        end
    end

    logic busy;
    assign busy = (state == ST_CONV);

    // ********************************************
    // Interrupts
    // ********************************************
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_DONE_BIT]  = conv_finish && !conv_abort;
        irq_set[IRQ_ABORT_BIT] = conv_abort;
    end

    // A set in the clearing cycle wins so no event is lost.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_stat ? req.wdata[IRQ_W-1:0] : '0)) | irq_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= req.wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((irq_stat & ~(wr_stat ? req.wdata[IRQ_W-1:0] : '0)) | irq_set)
                       & irq_mask);
        end
    end

    // ********************************************
    // Read data
    // ********************************************
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        unique case (req.addr)
            ADDR_CONTROL: begin
                next_rdata[SEL_MSB:SEL_LSB] = input_select_field;
                next_rdata[GO_BIT]          = busy;
                next_rdata[POWER_BIT]       = converter_power_bit;
                next_rdata = next_rdata & CONTROL_WR_MASK;
            end
            ADDR_BENCH: begin
                next_rdata[BENCH_EN_BIT] = bench_output_control;
            end
            ADDR_IRQ_STAT: begin
                next_rdata[IRQ_W-1:0] = irq_stat;
            end
            ADDR_IRQ_MASK: begin
                next_rdata[IRQ_W-1:0] = irq_mask;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= req.rd ? next_rdata : '0;
        end
    end

    // ********************************************
    // Analog outputs
    // ********************************************
    route_type route;

    adc_route_decode u_decode (
        .code_i      (input_select_field),
        .large_pkg_i (large_sync),
        .route_o     (route)
    );

    // Power follows the write itself, so a start pulse never reaches an unpowered core.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            converter_power_o <= 1'b0;
            conv_start_o      <= 1'b0;
        end else begin
            converter_power_o <= wr_control ? req.wdata[POWER_BIT] : converter_power_bit;
            conv_start_o      <= go_req && (state != ST_CONV);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            route_valid_o    <= 1'b0;
            route_internal_o <= 1'b0;
            route_pin_o      <= 1'b0;
            route_index_o    <= '0;
        end else begin
            route_valid_o    <= route.source_valid;
            route_internal_o <= route.source_internal;
            route_pin_o      <= route.source_pin;
            route_index_o    <= route.source_index;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bench_buffer_en_o <= 1'b0;
        end else begin
            bench_buffer_en_o <= bench_output_control && route.source_valid;
        end
    end
endmodule

// ### verification/adc_mux_control_properties.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/1ps
module adc_mux_control_properties
    import adc_mux_pkg::*;
#(
    parameter int unsigned CONV_CYCLES_P = CONV_CYCLES
) (
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0]        wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [7:0]        rdata_o,
    input wire logic              conv_done_i,
    input wire logic              large_pkg_i,
    input wire logic              converter_power_o,
    input wire logic              conv_start_o,
    input wire logic              route_valid_o,
    input wire logic              route_internal_o,
    input wire logic              route_pin_o,
    input wire logic [3:0]        route_index_o,
    input wire logic              bench_buffer_en_o,
    input wire logic              irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("Read data not zero outside a read answer.");
    a_bit7_zero: assert property ($past(rd_i) && $past(addr_i) == ADDR_CONTROL |-> !rdata_o[7])
        else $error("Control bit 7 read as one.");
    a_start_cause: assert property (conv_start_o |-> $past(wr_i) && $past(addr_i) == ADDR_CONTROL
        && $past(wdata_i[GO_BIT]) && $past(wdata_i[POWER_BIT]))
        else $error("Start pulse without a powered go write.");
    a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
        else $error("Start pulse longer than one cycle.");
    a_start_powered: assert property (conv_start_o |-> converter_power_o)
        else $error("Start pulse while converter unpowered.");
    a_power_write: assert property (wr_i && addr_i == ADDR_CONTROL
        |=> converter_power_o == $past(wdata_i[POWER_BIT]))
        else $error("Power output does not follow the written bit.");
    a_power_hold: assert property (!(wr_i && addr_i == ADDR_CONTROL) |=> $stable(converter_power_o))
        else $error("Power output changed without a write.");
    a_bench_route: assert property (bench_buffer_en_o |-> route_valid_o)
        else $error("Bench buffer enabled without a valid route.");
    a_route_kind: assert property (route_valid_o |-> route_internal_o != route_pin_o)
        else $error("Valid route is not exactly one kind.");
    a_route_reserved: assert property (route_valid_o && route_internal_o |-> route_index_o[3:1] != 3'b100)
        else $error("Reserved internal code routed.");
    a_pin_index: assert property (route_pin_o |-> !route_index_o[3])
        else $error("Pin channel index above seven.");
endmodule

bind adc_mux_control adc_mux_control_properties #(.CONV_CYCLES_P(CONV_CYCLES_P)) chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .conv_done_i(conv_done_i), .large_pkg_i(large_pkg_i),
    .converter_power_o(converter_power_o), .conv_start_o(conv_start_o),
    .route_valid_o(route_valid_o), .route_internal_o(route_internal_o),
    .route_pin_o(route_pin_o), .route_index_o(route_index_o),
    .bench_buffer_en_o(bench_buffer_en_o), .irq_o(irq_o));

// ### verification/adc_core_model.sv
// Behavioural model of the analog converter core that answers a start pulse.
`timescale 1ns/1ps
module adc_core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       conv_start_i,
    input  wire logic [7:0] delay_i,
    output logic            conv_done_o
);
    logic [7:0] count;
    logic       running;

    // A delay of zero models a core that never finishes, so the block must give up alone.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count <= 8'h00;
            running <= 1'b0;
            conv_done_o <= 1'b0;
        end else if (conv_start_i) begin
            count <= delay_i;
            running <= (delay_i != 8'h00);
            conv_done_o <= 1'b0;
        end else if (running) begin
            count <= count - 8'h01;
            if (count == 8'h01) begin
                running <= 1'b0;
                conv_done_o <= 1'b1;
            end
        end
    end
endmodule

// ### verification/adc_mux_control_tb.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module adc_mux_control_tb;
    import adc_mux_pkg::*;
    localparam int unsigned CONV_N = 40;
    logic              clk_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [7:0]        wdata_i = 8'h00;
    logic              wr_i = 1'b0;
    logic              rd_i = 1'b0;
    logic [7:0]        rdata_o;
    logic              conv_done;
    logic              large_pkg_i = 1'b0;
    logic              converter_power_o, conv_start_o, route_valid_o, route_internal_o;
    logic              route_pin_o, bench_buffer_en_o, irq_o;
    logic [3:0]        route_index_o;
    logic [7:0]        delay = 8'h05;
    int                errors = 0;
    int                n_tests = 0;

    always #2.5 clk_i = ~clk_i;

    adc_mux_control #(.CONV_CYCLES_P(CONV_N)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .conv_done_i(conv_done), .large_pkg_i(large_pkg_i),
        .converter_power_o(converter_power_o), .conv_start_o(conv_start_o),
        .route_valid_o(route_valid_o), .route_internal_o(route_internal_o),
        .route_pin_o(route_pin_o), .route_index_o(route_index_o),
        .bench_buffer_en_o(bench_buffer_en_o), .irq_o(irq_o));
    adc_core_model core (.clk_i(clk_i), .rst_n_i(rst_n_i), .conv_start_i(conv_start_o),
        .delay_i(delay), .conv_done_o(conv_done));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // Polls until the go flag drops; the poll bound covers the timeout plus the sync delay.
    task automatic wait_idle();
        logic [7:0] d;
        for (int k = 0; k < CONV_N; k++) begin
            rd(ADDR_CONTROL, d);
            if (d[GO_BIT] === 1'b0) break;
        end
    endtask

    task automatic results();
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #100us;
        errors++;
        results();
    end

    initial begin
        logic [7:0] d;
        logic [4:0] c;
        logic       v;
        logic       i;
        logic       p;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(ADDR_CONTROL, d); check(d, CONTROL_RESET);
        rd(ADDR_BENCH, d); check(d, 8'h00);
        rd(ADDR_IRQ_STAT, d); check(d, 8'h00);
        rd(4'h2, d); check(d, 8'h00);
        wr(ADDR_CONTROL, 8'hfd);
        wr(4'h2, 8'hff);
        rd(ADDR_CONTROL, d); check(d, 8'h7d);
        check({7'h0, converter_power_o}, 8'h01);
        wr(ADDR_BENCH, 8'h01);
        rd(ADDR_BENCH, d); check(d, 8'h01);
        for (int n = 0; n < 64; n++) begin
            c = n[4:0];
            large_pkg_i <= n[5];
            wr(ADDR_CONTROL, {1'b0, c, 2'b01});
            repeat (4) @(posedge clk_i);
            i = (c <= 5'h0f);
            p = (c[4:3] == 2'b11);
            v = (i && c != SEL_RSVD_A && c != SEL_RSVD_B) || (p && (c <= 5'h1c || n[5]));
            check({6'h0, route_valid_o, bench_buffer_en_o}, {6'h0, v, v});
            if (v) check({route_internal_o, route_pin_o, 2'b00, route_index_o},
                {i, p, 2'b00, i ? c[3:0] : {1'b0, c[2:0]}});
        end
        wr(ADDR_BENCH, 8'h00);
        rd(ADDR_CONTROL, d); check({7'h0, bench_buffer_en_o}, 8'h00);
        for (int m = 1; m >= 0; m--) begin
            wr(ADDR_IRQ_MASK, m[7:0]);
            rd(ADDR_IRQ_MASK, d); check(d, m[7:0]);
            wr(ADDR_CONTROL, 8'h0f);
            #1 check({7'h0, conv_start_o}, 8'h01);
            rd(ADDR_CONTROL, d); check(d, 8'h0f);
            repeat (12) @(posedge clk_i);
            rd(ADDR_CONTROL, d); check(d, 8'h0d);
            rd(ADDR_IRQ_STAT, d); check(d, 8'h01);
            check({7'h0, irq_o}, m[7:0]);
            wr(ADDR_IRQ_STAT, 8'h01);
            rd(ADDR_IRQ_STAT, d); check(d, 8'h00);
        end
        delay <= 8'h00;
        wr(ADDR_IRQ_MASK, 8'h03);
        wr(ADDR_CONTROL, 8'h0f);
        repeat (CONV_N - 2) @(posedge clk_i);
        rd(ADDR_CONTROL, d); check(d, 8'h0f);
        wait_idle();
        rd(ADDR_CONTROL, d); check(d, 8'h0d);
        rd(ADDR_IRQ_STAT, d); check(d, 8'h01);
        wr(ADDR_IRQ_STAT, 8'h01);
        wr(ADDR_CONTROL, 8'h0f);
        wr(ADDR_CONTROL, 8'h0c);
        rd(ADDR_CONTROL, d); check(d, 8'h0c);
        rd(ADDR_IRQ_STAT, d); check(d, 8'h02);
        check({7'h0, converter_power_o}, 8'h00);
        check({7'h0, irq_o}, 8'h01);
        wr(ADDR_IRQ_STAT, 8'h02);
        wr(ADDR_CONTROL, 8'h02);
        rd(ADDR_CONTROL, d); check(d, 8'h00);
        rd(ADDR_IRQ_STAT, d); check(d, 8'h00);
        check({7'h0, irq_o}, 8'h00);
        results();
    end
endmodule
